/* hdl/bridge_driver_serial_regs.sv */
// serial register interface of the full-bridge gate driver
`timescale 1ns/10ps
`include "bridge_serial_consts.svh"
module bridge_driver_serial_regs
  import bridge_serial_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic frame_strobe_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic [9:0] gate_fault,
  input wire logic [9:0] reg_vds_fault,
  input wire logic [9:0] supply_load_fault,
  input wire logic [9:0] verify_a_event,
  input wire logic [9:0] verify_b_event,
  input wire logic [3:0] monitor_fault,
  output logic [3:0] oc_verify_time,
  output logic [5:0] dead_time_count,
  output logic [9:0] oc_verify_cycles,
  output logic [8:0] dead_time_cycles,
  output logic [9:0] overcurrent_lowside_cfg,
  output logic oc_qualifier_select,
  output logic vds_qualifier_select,
  output logic [9:0] qualifier_highside_cfg,
  output logic [3:0] openload_threshold,
  output logic [5:0] vds_verify_time,
  output logic [9:0] vds_verify_cycles,
  output logic [9:0] monitor_enable_cfg,
  output logic [9:0] sense_amp_cfg,
  output logic [9:0] verify_cmd_a,
  output logic [9:0] verify_cmd_b,
  output logic bootstrap_mgmt_disable,
  output logic short_fault_action,
  output logic phase_a_upper_gate,
  output logic phase_a_lower_gate,
  output logic phase_b_upper_gate,
  output logic phase_b_lower_gate,
  output logic summary_fault_flag,
  output logic serial_error_flag
);

  // ***************************
  // helpers
  // ***************************
  // read-only addresses: verify results and diagnostics
  function automatic logic is_ro(input logic [3:0] a);
    is_ro = (a == `ADDR_VERIFY_RES_A) || (a == `ADDR_VERIFY_RES_B) ||
            (a == `ADDR_GATE_FAULT) || (a == `ADDR_REG_VDS_FAULT) ||
            (a == `ADDR_SUPPLY_FAULT);
  endfunction : is_ro

  // power-on value of each register
  function automatic reg_word_t rst_val(input logic [3:0] a);
    unique case (a)
      `ADDR_BRIDGE_TIMING: rst_val = `RST_BRIDGE_TIMING;
      `ADDR_OC_LOWSIDE: rst_val = `RST_OC_LOWSIDE;
      `ADDR_QUAL_HIGHSIDE: rst_val = `RST_QUAL_HIGHSIDE;
      `ADDR_OPENLOAD_VDS: rst_val = `RST_OPENLOAD_VDS;
      `ADDR_MONITOR_EN: rst_val = `RST_MONITOR_EN;
      `ADDR_SENSE_AMP: rst_val = `RST_SENSE_AMP;
      `ADDR_BRIDGE_CTRL: rst_val = `RST_BRIDGE_CTRL;
      default: rst_val = 10'h000;
    endcase
  endfunction : rst_val

  // 16-bit frame from 15 data bits plus odd parity
  function automatic logic [15:0] mk_frame(input logic [14:0] w);
    mk_frame = {w, ~^w};
  endfunction : mk_frame

  // step count times cycles per step
  function automatic logic [9:0] scale(input logic [5:0] n, input int step);
    scale = 10'(int'(n) * step);
  endfunction : scale

  // ***************************
  // link domain
  // ***************************
  logic [15:0] rx_q;
  logic [4:0] hdr_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic fst_q;
  logic tog_q;
  logic hdr_rdy_q;
  logic [3:0] idx_q;
  logic [15:0] tx_q;
  logic [14:0] stat_w;

  // first-edge flag, preset while the strobe is high
  always_ff @(posedge serial_clk or posedge frame_strobe_n) begin
    if (frame_strobe_n) begin
      fst_q <= 1'b1;
    end else begin
      fst_q <= 1'b0;
    end
  end

  // data shifts only while the strobe is low
  always_ff @(posedge serial_clk) begin
    if (!frame_strobe_n) begin
      rx_q <= {rx_q[14:0], serial_data_in};
    end
  end

  // header kept apart so the sys side can read it mid-frame
  always_ff @(posedge serial_clk) begin
    if (!frame_strobe_n && !fst_q && cnt_q == `HDR_CNT) begin
      hdr_q <= {rx_q[3:0], serial_data_in};
    end
  end

  // edge count saturates so an overlong frame stays detectable
  assign cnt_d = fst_q ? 5'd1 : (cnt_q == `FRAME_CNT_MAX) ? cnt_q : cnt_q + 5'd1;

  // count survives the strobe rise; toggle marks a frame with edges
  always_ff @(posedge serial_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 5'd0;
      tog_q <= 1'b0;
    end else if (!frame_strobe_n) begin
      cnt_q <= cnt_d;
      tog_q <= tog_q ^ fst_q;
    end
  end

  // header-ready level, dropped as soon as the strobe rises
  always_ff @(posedge serial_clk or posedge frame_strobe_n) begin
    if (frame_strobe_n) begin
      hdr_rdy_q <= 1'b0;
    end else if (!fst_q && cnt_q == `HDR_CNT) begin
      hdr_rdy_q <= 1'b1;
    end
  end

  // output index follows rising edges, so a leading fall does not skip the msb
  always_ff @(negedge serial_clk or posedge frame_strobe_n) begin
    if (frame_strobe_n) begin
      idx_q <= 4'd0;
    end else if (!fst_q) begin
      idx_q <= (cnt_q > 5'd15) ? 4'd15 : cnt_q[3:0];
    end
  end

  // first bit is the live fault flag; later bits come from the frozen word
  assign serial_data_out = (idx_q == 4'd0) ? stat_w[`STAT_FAULT_BIT] : tx_q[4'd15 - idx_q];
  assign serial_data_oe = !frame_strobe_n;

  // ***************************
  // crossing into clk_sys
  // ***************************
  logic stb_s1;
  logic stb_s2;
  logic stb_s3;
  logic hdr_s1;
  logic hdr_s2;
  logic tog_s1;
  logic tog_s2;
  logic tog_seen_q;

  // two-flop synchronisers; the third strobe flop feeds edge detection only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {stb_s1, stb_s2, stb_s3} <= 3'b111;
      {hdr_s1, hdr_s2} <= 2'b00;
      {tog_s1, tog_s2, tog_seen_q} <= 3'b000;
    end else begin
      {stb_s1, stb_s2, stb_s3} <= {frame_strobe_n, stb_s1, stb_s2};
      {hdr_s1, hdr_s2} <= {hdr_rdy_q, hdr_s1};
      {tog_s1, tog_s2} <= {tog_q, tog_s1};
      if (stb_s2 && !stb_s3) begin
        tog_seen_q <= tog_s2;
      end
    end
  end

  // ***************************
  // frame decode
  // ***************************
  logic st_fall;
  logic st_rise;
  logic fr_end;
  logic f_ok;
  logic [3:0] f_addr;
  logic f_wr;
  reg_word_t f_data;
  logic good_end;
  logic bad_end;
  logic wr_hit;
  logic cor_hit;

  // rx and count are quiet while the strobe is high, so they are read after the rise
  assign st_fall = !stb_s2 && stb_s3;
  assign st_rise = stb_s2 && !stb_s3;
  assign fr_end = st_rise && (tog_s2 != tog_seen_q); // no edges at all: a silent poll
  assign f_ok = (cnt_q == 5'(`FRAME_BITS)) && (^rx_q);
  assign f_addr = rx_q[15:12];
  assign f_wr = rx_q[11];
  assign f_data = rx_q[10:1];
  assign good_end = fr_end && f_ok;
  assign bad_end = fr_end && !f_ok;
  assign wr_hit = good_end && f_wr && !is_ro(f_addr);
  assign cor_hit = good_end && !f_wr && is_ro(f_addr);

  // ***************************
  // register file
  // ***************************
  reg_word_t regs_q [`NUM_REGS];
  reg_word_t reg_d [`NUM_REGS];
  reg_word_t set_v [`NUM_REGS];
  reg_word_t msk_gate;
  reg_word_t msk_regvds;
  reg_word_t msk_supply;
  reg_word_t m0;
  reg_word_t m1;

  // mask bits mapped onto diagnostic bit positions
  assign m0 = regs_q[`ADDR_DIAG_DIS_A];
  assign m1 = regs_q[`ADDR_DIAG_DIS_B];
  assign msk_gate = {6'h00, m0[3:0]};
  assign msk_regvds = {m1[9:8], 4'h0, m1[3:0]};
  assign msk_supply = {{2{m1[`MSK_VS]}}, 1'b0, {2{m0[`MSK_VBS]}}, 5'h00};

  // event sources per register; masked diagnostics never set
  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      set_v[i] = 10'h000;
    end
    set_v[`ADDR_VERIFY_RES_A] = verify_a_event;
    set_v[`ADDR_VERIFY_RES_B] = verify_b_event;
    set_v[`ADDR_GATE_FAULT] = gate_fault & ~msk_gate;
    set_v[`ADDR_REG_VDS_FAULT] = reg_vds_fault & ~msk_regvds;
    set_v[`ADDR_SUPPLY_FAULT] = supply_load_fault & ~msk_supply;
  end

  // next values: writes to writable words, clear-then-set on read-only ones
  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      reg_d[i] = regs_q[i];
      if (is_ro(4'(i))) begin
        // a fault arriving in the clearing cycle survives
        reg_d[i] = ((cor_hit && f_addr == 4'(i)) ? 10'h000 : regs_q[i]) | set_v[i];
      end else if (wr_hit && f_addr == 4'(i)) begin
        reg_d[i] = f_data;
      end
    end
  end

  // power-on returns every register to its default
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_q[i] <= rst_val(4'(i));
      end
    end else begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_q[i] <= reg_d[i];
      end
    end
  end

  // ***************************
  // status word
  // ***************************
  logic por_q;
  logic serr_q;
  logic [3:0] mon_q;
  logic [3:0] mon_msk;
  reg_word_t dg0;
  reg_word_t dg1;
  reg_word_t dg2;

  assign dg0 = regs_q[`ADDR_GATE_FAULT];
  assign dg1 = regs_q[`ADDR_REG_VDS_FAULT];
  assign dg2 = regs_q[`ADDR_SUPPLY_FAULT];
  assign mon_msk = {1'b0, m0[`MSK_TW], m1[`MSK_VLO], 1'b0};

  // power flag and latched monitors clear on any good frame; a present fault re-sets
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      por_q <= 1'b1;
      serr_q <= 1'b0;
      mon_q <= 4'h0;
    end else begin
      por_q <= por_q && !good_end;
      serr_q <= bad_end || (serr_q && !good_end);
      mon_q <= (good_end ? 4'h0 : mon_q) | (monitor_fault & ~mon_msk);
    end
  end

  // summary bits other than the power, error and monitor flags are views of the diagnostic registers, cleared only through them
  assign stat_w[13:0] = {por_q, serr_q, 1'b0, mon_q[3], mon_q[2], |dg2[9:8], mon_q[1], mon_q[0],
                         |dg1[9:8], 1'b0, |dg2[2:0], |dg2[6:5], |dg0[3:0], |dg1[3:0]};
  assign stat_w[`STAT_FAULT_BIT] = |stat_w[13:0];
  assign summary_fault_flag = stat_w[`STAT_FAULT_BIT];
  assign serial_error_flag = serr_q;

  // ***************************
  // readback word
  // ***************************
  frame_state_t st_q;
  frame_state_t st_d;
  logic [15:0] tx_d;
  reg_word_t tail_w;

  // writes of any address return the status tail; reads return the register
  assign tail_w = hdr_q[0] ? stat_w[9:0] : regs_q[hdr_q[4:1]];

  // status snapshot at strobe fall, refined once the header is known
  always_comb begin
    st_d = st_q;
    tx_d = tx_q;
    unique case (st_q)
      ST_IDLE: begin
        if (st_fall) begin
          st_d = ST_OPEN;
          tx_d = mk_frame(stat_w);
        end
      end
      ST_OPEN: begin
        if (st_rise) begin
          st_d = ST_IDLE;
        end else if (hdr_s2) begin
          st_d = ST_HDR;
          tx_d = mk_frame({tx_q[15:11], tail_w});
        end
      end
      ST_HDR: begin
        if (st_rise) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  // tx is frozen between updates so the link side reads a settled word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      tx_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      tx_q <= tx_d;
    end
  end

  // ***************************
  // configuration outputs
  // ***************************
  reg_word_t tmg;
  reg_word_t olv;
  reg_word_t ctl;
  reg_word_t q2;
  logic [5:0] dead_eff;

  assign tmg = regs_q[`ADDR_BRIDGE_TIMING];
  assign olv = regs_q[`ADDR_OPENLOAD_VDS];
  assign ctl = regs_q[`ADDR_BRIDGE_CTRL];
  assign q2 = regs_q[`ADDR_QUAL_HIGHSIDE];
  assign oc_verify_time = tmg[9:`OC_TIME_LSB];
  assign dead_time_count = tmg[`DEAD_TIME_MSB:0];
  assign openload_threshold = olv[9:`OPENLOAD_THR_LSB];
  assign vds_verify_time = olv[`VDS_TIME_MSB:0];
  assign oc_qualifier_select = q2[`OC_QUAL_BIT];
  assign vds_qualifier_select = q2[`VDS_QUAL_BIT];
  assign qualifier_highside_cfg = q2;
  assign overcurrent_lowside_cfg = regs_q[`ADDR_OC_LOWSIDE];
  assign monitor_enable_cfg = regs_q[`ADDR_MONITOR_EN];
  assign sense_amp_cfg = regs_q[`ADDR_SENSE_AMP];
  assign verify_cmd_a = regs_q[`ADDR_VERIFY_CMD_A];
  assign verify_cmd_b = regs_q[`ADDR_VERIFY_CMD_B];
  assign bootstrap_mgmt_disable = ctl[`BOOT_DIS_BIT];
  assign short_fault_action = ctl[`SHORT_ACT_BIT];
  assign phase_b_upper_gate = ctl[`PB_UPPER_BIT];
  assign phase_b_lower_gate = ctl[`PB_LOWER_BIT];
  assign phase_a_upper_gate = ctl[`PA_UPPER_BIT];
  assign phase_a_lower_gate = ctl[`PA_LOWER_BIT];
  // a dead-time code of one is raised to the 100 ns floor
  assign dead_eff = (dead_time_count == 6'd1) ? 6'd2 : dead_time_count;

  // cycle counts registered so the analog side sees settled values
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oc_verify_cycles <= 10'h000;
      dead_time_cycles <= 9'h000;
      vds_verify_cycles <= 10'h000;
    end else begin
      oc_verify_cycles <= scale({2'b00, oc_verify_time}, `OCV_STEP_CYC);
      dead_time_cycles <= 9'(scale(dead_eff, `DEAD_STEP_CYC));
      vds_verify_cycles <= scale(vds_verify_time, `VDV_STEP_CYC);
    end
  end

  // ***************************
  // assertions
  // ***************************
  property p_shift;
    @(posedge serial_clk) disable iff (frame_strobe_n)
    1'b1 |=> rx_q[0] == $past(serial_data_in);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted in");

  property p_count;
    @(posedge serial_clk) disable iff (frame_strobe_n)
    (!fst_q && cnt_q < `FRAME_CNT_MAX) |=> cnt_q == $past(cnt_q) + 5'd1;
  endproperty
  a_count: assert property (p_count) else $error("edge count wrong");

  property p_release;
    @(posedge clk_sys) disable iff (!reset_n)
    frame_strobe_n |-> !serial_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven while strobe high");

  property p_err_set;
    @(posedge clk_sys) disable iff (!reset_n)
    bad_end |=> serial_error_flag && $stable(regs_q[`ADDR_BRIDGE_TIMING]);
  endproperty
  a_err_set: assert property (p_err_set) else $error("bad frame not flagged");

  property p_err_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    serr_q && !good_end |=> serr_q;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("serial error lost");

  property p_write;
    @(posedge clk_sys) disable iff (!reset_n)
    good_end && f_wr && f_addr == `ADDR_BRIDGE_CTRL |=> ctl == $past(rx_q[10:1]);
  endproperty
  a_write: assert property (p_write) else $error("write not stored");

  property p_read_keeps;
    @(posedge clk_sys) disable iff (!reset_n)
    fr_end && !f_wr && f_addr == `ADDR_BRIDGE_CTRL |=> $stable(ctl);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed register");

  property p_cor;
    @(posedge clk_sys) disable iff (!reset_n)
    cor_hit && f_addr == `ADDR_GATE_FAULT |=> dg0 == $past(set_v[`ADDR_GATE_FAULT]);
  endproperty
  a_cor: assert property (p_cor) else $error("diagnostic not cleared by read");

  property p_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    m0[2] && !dg0[2] |=> !dg0[2];
  endproperty
  a_mask: assert property (p_mask) else $error("masked diagnostic set");

  property p_parity;
    @(posedge clk_sys) disable iff (!reset_n)
    st_q == ST_HDR |-> ^tx_q;
  endproperty
  a_parity: assert property (p_parity) else $error("readback parity even");

  property p_top5;
    @(posedge clk_sys) disable iff (!reset_n)
    st_q == ST_IDLE && st_fall |=> tx_q[15:11] == $past(stat_w[14:10]);
  endproperty
  a_top5: assert property (p_top5) else $error("status head missing");

  c_write: cover property (@(posedge clk_sys) disable iff (!reset_n) wr_hit);
  c_cor: cover property (@(posedge clk_sys) disable iff (!reset_n) cor_hit);
  c_err: cover property (@(posedge clk_sys) disable iff (!reset_n) bad_end);
  c_poll: cover property (@(posedge clk_sys) disable iff (!reset_n) st_rise && !fr_end);

endmodule : bridge_driver_serial_regs

/* inc/bridge_serial_consts.svh */
// offsets, field positions, reset values and timing counts of the serial register block
`ifndef BRIDGE_SERIAL_CONSTS_SVH
`define BRIDGE_SERIAL_CONSTS_SVH
// ***************************
// frame layout
// ***************************
`define FRAME_BITS 16
`define FRAME_CNT_MAX 5'd17
`define HDR_CNT 5'd4
`define NUM_REGS 16
// ***************************
// register addresses
// ***************************
`define ADDR_BRIDGE_TIMING 4'h0
`define ADDR_OC_LOWSIDE 4'h1
`define ADDR_QUAL_HIGHSIDE 4'h2
`define ADDR_OPENLOAD_VDS 4'h3
`define ADDR_MONITOR_EN 4'h4
`define ADDR_SENSE_AMP 4'h5
`define ADDR_VERIFY_CMD_A 4'h6
`define ADDR_VERIFY_CMD_B 4'h7
`define ADDR_VERIFY_RES_A 4'h8
`define ADDR_VERIFY_RES_B 4'h9
`define ADDR_DIAG_DIS_A 4'ha
`define ADDR_DIAG_DIS_B 4'hb
`define ADDR_GATE_FAULT 4'hc
`define ADDR_REG_VDS_FAULT 4'hd
`define ADDR_SUPPLY_FAULT 4'he
`define ADDR_BRIDGE_CTRL 4'hf
// ***************************
// reset values
// ***************************
`define RST_BRIDGE_TIMING 10'h3e0
`define RST_OC_LOWSIDE 10'h258
`define RST_QUAL_HIGHSIDE 10'h018
`define RST_OPENLOAD_VDS 10'h210
`define RST_MONITOR_EN 10'h060
`define RST_SENSE_AMP 10'h0f5
`define RST_BRIDGE_CTRL 10'h040
// ***************************
// field positions
// ***************************
`define OC_TIME_LSB 6
`define DEAD_TIME_MSB 5
`define OC_QUAL_BIT 9
`define VDS_QUAL_BIT 8
`define OPENLOAD_THR_LSB 6
`define VDS_TIME_MSB 5
`define BOOT_DIS_BIT 7
`define SHORT_ACT_BIT 6
`define PB_UPPER_BIT 3
`define PB_LOWER_BIT 2
`define PA_UPPER_BIT 1
`define PA_LOWER_BIT 0
`define MSK_VBS 7
`define MSK_TW 6
`define MSK_VS 7
`define MSK_VLO 6
`define STAT_FAULT_BIT 14
// ***************************
// timing
// ***************************
`define CLK_PERIOD_NS 10
`define OCV_STEP_NS 500
`define DEAD_STEP_NS 50
`define VDV_STEP_NS 100
`define OCV_STEP_CYC (`OCV_STEP_NS / `CLK_PERIOD_NS)
`define DEAD_STEP_CYC (`DEAD_STEP_NS / `CLK_PERIOD_NS)
`define VDV_STEP_CYC (`VDV_STEP_NS / `CLK_PERIOD_NS)
`endif

/* inc/bridge_serial_pkg.sv */
// types shared by the serial register block
package bridge_serial_pkg;
  typedef logic [9:0] reg_word_t;
  // sys-side view of a frame
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OPEN = 3'b010,
    ST_HDR = 3'b100
  } frame_state_t;
endpackage : bridge_serial_pkg

/* test/serial_host.sv */
// host-side serial master model that runs one frame at a time
`timescale 1ns/10ps
module serial_host (
  output logic sck,
  output logic strobe_n,
  output logic sdi,
  input wire logic sdo
);
  // ***************************
  // idle state
  // ***************************
  // clock stands still low outside frames
  initial begin
    sck = 1'b0;
    strobe_n = 1'b1;
    sdi = 1'b0;
  end
  // send nr rising edges of w msb first; reply bit k sampled before rise 16-k
  task automatic xfer(input logic [15:0] w, input int nr, output logic [15:0] rx);
    rx = '0;
    strobe_n = 1'b0;
    #50;
    for (int i = 0; i < nr; i++) begin
      sdi = w[15 - (i % 16)];
      #40;
      if (i < 16) rx[15 - i] = sdo;
      sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 strobe_n = 1'b1;
    sdi = ~sdi; // released line never keeps its last value
    #100;
  endtask : xfer
  // zero-edge poll: only the leading bit is looked at
  task automatic poll(output logic b);
    strobe_n = 1'b0;
    #50 b = sdo;
    strobe_n = 1'b1;
    #100;
  endtask : poll
endmodule : serial_host

/* test/tb_bridge_driver_serial_regs.sv */
// self-checking bench for the serial register block
`timescale 1ns/10ps
`include "bridge_serial_consts.svh"
module tb_bridge_driver_serial_regs;
  logic clk_sys, reset_n, sck, stb_n, sdi, sdo, oe, flt, sef, ocsel, vdsel, pau, pal, pbu, pbl, por, serr, b;
  logic bmd, sfa;
  logic [9:0] gf, va, d, ocy, vcy, c1, c2, c4, c5, c6, c7;
  logic [9:0] m [16];
  logic [8:0] dcy;
  logic [5:0] dtc, vtm;
  logic [3:0] tocp, olth;
  int errors, checked;
  int wa [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 15};
  int bad [3] = '{8, 17, 16};
  serial_host host (.sck(sck), .strobe_n(stb_n), .sdi(sdi), .sdo(sdo));
  bridge_driver_serial_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .serial_clk(sck),
    .frame_strobe_n(stb_n), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe(oe),
    .gate_fault(gf), .reg_vds_fault(10'h000), .supply_load_fault(10'h000), .verify_a_event(va),
    .verify_b_event(10'h000), .monitor_fault(4'h0), .oc_verify_time(tocp), .dead_time_count(dtc),
    .oc_verify_cycles(ocy), .dead_time_cycles(dcy), .overcurrent_lowside_cfg(c1), .oc_qualifier_select(ocsel),
    .vds_qualifier_select(vdsel), .qualifier_highside_cfg(c2), .openload_threshold(olth), .vds_verify_time(vtm),
    .vds_verify_cycles(vcy), .monitor_enable_cfg(c4), .sense_amp_cfg(c5), .verify_cmd_a(c6), .verify_cmd_b(c7),
    .bootstrap_mgmt_disable(bmd), .short_fault_action(sfa), .phase_a_upper_gate(pau), .phase_a_lower_gate(pal),
    .phase_b_upper_gate(pbu), .phase_b_lower_gate(pbl), .summary_fault_flag(flt), .serial_error_flag(sef));
  // ***************************
  // helpers
  // ***************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // status word of the model; only the gate undervoltage summary can be live here
  function automatic logic [14:0] stw();
    logic [14:0] s;
    s = {1'b0, por, serr, 10'h000, |m[12][3:0], 1'b0};
    s[14] = |s[13:0];
    return s;
  endfunction : stw
  // one frame: predict the reply, send it, then update the model
  task automatic frm(input logic [3:0] a, input logic w, input logic [9:0] dd, input int nr, input logic bp);
    logic [15:0] f, rx, ex;
    logic [14:0] s;
    logic ro;
    f = {a, w, dd, 1'b0};
    f[0] = ~^f[15:1] ^ bp;
    s = stw();
    ro = a inside {4'h8, 4'h9, 4'hc, 4'hd, 4'he};
    ex = {s[14:10], w ? s[9:0] : m[a], 1'b0};
    ex[0] = ~^ex[15:1];
    host.xfer(f, nr, rx);
    if (nr == 16 && !bp) begin
      chk("reply", rx, ex);
      por = 1'b0;
      serr = 1'b0;
      if (w && !ro) m[a] = dd;
      if (!w && ro) m[a] = '0;
    end else begin
      serr = 1'b1;
    end
    s = stw();
    chk("serial error", sef, serr);
    chk("fault flag", flt, s[14]);
  endtask : frm
  // fault level held for a few system cycles, then removed
  task automatic pulse();
    @(posedge clk_sys) #1 gf = 10'h004;
    repeat (3) @(posedge clk_sys);
    #1 gf = '0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse
  // hang guard
  initial begin
    #500000;
    errors++;
    $display("MISMATCH timeout expected end seen hang");
    stop_test();
  end
  // ***************************
  // main sequence
  // ***************************
  initial begin
    errors = 0;
    checked = 0;
    reset_n = 1'b0;
    gf = '0;
    va = '0;
    por = 1'b1;
    serr = 1'b0;
    for (int i = 0; i < 16; i++) m[i] = '0;
    m[0] = `RST_BRIDGE_TIMING;
    m[1] = `RST_OC_LOWSIDE;
    m[2] = `RST_QUAL_HIGHSIDE;
    m[3] = `RST_OPENLOAD_VDS;
    m[4] = `RST_MONITOR_EN;
    m[5] = `RST_SENSE_AMP;
    m[15] = `RST_BRIDGE_CTRL;
    void'($urandom(32'h77f8));
    repeat (12) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("oe idle", oe, 1'b0);
    for (int a = 0; a < 16; a++) frm(a[3:0], 1'b0, 10'h3ff, 16, 1'b0);
    $display("test defaults done");
    // verify commands and masks stay zero so no sequence starts
    foreach (wa[k]) begin
      d = 10'($urandom);
      if (wa[k] inside {6, 7, 10, 11}) d = '0;
      frm(wa[k][3:0], 1'b1, d, 16, 1'b0);
      frm(wa[k][3:0], 1'b0, ~d, 16, 1'b0);
    end
    chk("gates", {pbu, pbl, pau, pal}, m[15][3:0]);
    chk("control", {bmd, sfa}, m[15][7:6]);
    chk("qualifiers", {ocsel, vdsel}, m[2][9:8]);
    chk("config words", {c1, c2, c4, c5, c6, c7}, {m[1], m[2], m[4], m[5], m[6], m[7]});
    chk("vds fields", {olth, vtm}, m[3]);
    chk("vds cycles", vcy, m[3][5:0] * 10);
    frm(4'h0, 1'b1, 10'h0c1, 16, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("dead code", dtc, 6'h01);
    chk("oc time", tocp, 4'h3);
    chk("oc cycles", ocy, 10'd150);
    chk("dead cycles", dcy, 9'd10);
    $display("test write read done");
    foreach (bad[k]) frm(4'h1, 1'b1, 10'h2aa, bad[k], k == 2);
    frm(4'h1, 1'b0, 10'h000, 16, 1'b0);
    frm(4'hc, 1'b1, 10'h3ff, 16, 1'b0);
    $display("test refusals done");
    frm(4'ha, 1'b1, 10'h004, 16, 1'b0);
    pulse();
    frm(4'hc, 1'b0, 10'h000, 16, 1'b0);
    frm(4'ha, 1'b1, 10'h000, 16, 1'b0);
    pulse();
    m[12] = 10'h004;
    host.poll(b);
    chk("poll flag", b, 1'b1);
    chk("poll error", sef, 1'b0);
    frm(4'hc, 1'b0, 10'h000, 16, 1'b0);
    frm(4'hc, 1'b0, 10'h000, 16, 1'b0);
    $display("test diagnostics done");
    // random verify result held one cycle, then read back twice
    d = 10'($urandom);
    @(posedge clk_sys) #1 va = d;
    @(posedge clk_sys) #1 va = '0;
    m[8] = d;
    frm(4'h8, 1'b0, 10'h000, 16, 1'b0);
    frm(4'h8, 1'b0, 10'h000, 16, 1'b0);
    $display("test verify results done");
    stop_test();
  end
endmodule : tb_bridge_driver_serial_regs
